// ### rtl/stm_timer.sv
/*
 * 16-bit count-up timer with comparator a (full word) and comparator p
 * (upper byte): compare output, timer/counter, pwm and single pulse modes.
 * assumes a synchronous avalon-mm master on CORE_CLK_IN and an external
 * clock pin and output pin from outside the clock domain / pad logic.
 */
// Function
// - period byte compared to counter bits 15:8; zero means 65536 clocks, else 256 times.
// - mode 00 is compare output; clears by overflow, match a or match p.
// - clear select low: clear on p match or overflow; both flags set.
// - clear select high: clear on a match; only flag a is set.
// - in compare mode only an a match or counter on rising changes the output pin.
// - a match drives pin high, low or toggles per function; zero no change.
// - counter on rising in compare mode loads pin with output control level.
// - mode 11 counts and flags like compare mode but leaves pin undriven.
// - mode 10 with function 10 generates fixed frequency pwm.
// - swap low: period from p byte, duty from a; swap high exchanges roles.
// - duty at or above period holds pwm output fully active.
// - pwm mode sets flag a on a match and flag p on p match.
// - pwm: output control picks active level, function forces or enables, invert flips.
// - pwm counting continues while function forces a fixed level.
// - pwm ignores clear select; the swap choice alone clears the counter.
// - mode 10 with function 11 generates a single pulse.
// - single pulse: counter on rising starts counter and pulse leading edge.
// - single pulse: external pin active edge sets counter on.
// - pulse ends on software clear or a match; a match also stops counter.
// - counter on rising zeroes counter; falling stops and keeps value.
// - hold bit freezes counter; counting resumes from that value.
`timescale 1ns/1ps
`default_nettype none
module stm_timer #(
    parameter int TBC_DIV = 256              // slow base clock divider
) (
    input  wire logic        CORE_CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic [7:0]  AVS_ADDRESS_IN,
    input  wire logic        AVS_READ_IN,
    input  wire logic        AVS_WRITE_IN,
    input  wire logic [31:0] AVS_WRITEDATA_IN,
    input  wire logic [3:0]  AVS_BYTEENABLE_IN,
    output var  logic [31:0] AVS_READDATA_OUT,
    output var  logic        AVS_WAITREQUEST_OUT,
    input  wire logic        EXT_CLOCK_PIN_IN,
    output var  logic        TIMER_OUT,
    output var  logic        TIMER_OE_N_OUT
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // period byte to clocks; zero stands for the full 16-bit range
    function automatic logic [16:0] byte_span(input logic [7:0] b);
        byte_span = (b == 8'h00) ? 17'h10000 : {1'b0, b, 8'h00};
    endfunction : byte_span

    function automatic logic [16:0] word_span(input logic [15:0] w);
        word_span = (w == 16'h0000) ? 17'h10000 : {1'b0, w};
    endfunction : word_span

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    stm_pkg::stm_ctrl1_t ctrl1_reg;
    logic [2:0]  clk_sel_reg;
    logic        counter_on_reg;
    logic        counter_hold_reg;
    logic        on_prev_reg;
    logic [15:0] compare_a_value_reg;
    logic [7:0]  period_value_reg;
    logic [15:0] count_reg;
    logic        match_a_flag_reg;
    logic        match_p_flag_reg;
    logic        out_level_reg;
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic        pin_meta_reg;
    logic        pin_sync_reg;
    logic        pin_last_reg;
    logic [7:0]  prescale_reg;
    logic        pin_out_reg;
    logic        pin_oe_n_reg;

    // ----------------------------------------------------------------
    // avalon slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    logic       access_now;
    logic       wr_now;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    assign access_now = (AVS_READ_IN | AVS_WRITE_IN) & wait_reg;
    assign wr_now     = AVS_WRITE_IN & ~wait_reg & AVS_BYTEENABLE_IN[0];
    assign wr_byte    = AVS_WRITEDATA_IN[7:0];

    // waitrequest drops for exactly one cycle per request
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            wait_reg <= 1'b1;
        end else begin
            wait_reg <= ~access_now;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (AVS_ADDRESS_IN)
            stm_pkg::OFS_TIMER_CONTROL_ZERO:
                rd_byte = {counter_hold_reg, clk_sel_reg, counter_on_reg, 3'h0};
            stm_pkg::OFS_TIMER_CONTROL_ONE: rd_byte = ctrl1_reg;
            stm_pkg::OFS_COUNT_LOW:         rd_byte = count_reg[7:0];
            stm_pkg::OFS_COUNT_HIGH:        rd_byte = count_reg[15:8];
            stm_pkg::OFS_COMPARE_A_LOW:     rd_byte = compare_a_value_reg[7:0];
            stm_pkg::OFS_COMPARE_A_HIGH:    rd_byte = compare_a_value_reg[15:8];
            stm_pkg::OFS_PERIOD_COMPARE:    rd_byte = period_value_reg;
            stm_pkg::OFS_MATCH_STATUS:
                rd_byte = {6'h00, match_p_flag_reg, match_a_flag_reg};
            default:                        rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            rdata_reg <= 32'h0000_0000;
        end else if (access_now) begin
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // ----------------------------------------------------------------
    // plain configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            ctrl1_reg           <= stm_pkg::stm_ctrl1_t'(stm_pkg::RST_BYTE);
            clk_sel_reg         <= 3'h0;
            counter_hold_reg    <= 1'b0;
            compare_a_value_reg <= 16'h0000;
            period_value_reg    <= stm_pkg::RST_BYTE;
        end else if (wr_now) begin
            unique case (AVS_ADDRESS_IN)
                stm_pkg::OFS_TIMER_CONTROL_ZERO: begin
                    counter_hold_reg <= wr_byte[stm_pkg::BIT_COUNTER_HOLD];
                    clk_sel_reg      <= wr_byte[stm_pkg::BIT_CLK_SEL_LSB +: 3];
                end
                stm_pkg::OFS_TIMER_CONTROL_ONE: ctrl1_reg <= stm_pkg::stm_ctrl1_t'(wr_byte);
                stm_pkg::OFS_COMPARE_A_LOW:     compare_a_value_reg[7:0] <= wr_byte;
                stm_pkg::OFS_COMPARE_A_HIGH:    compare_a_value_reg[15:8] <= wr_byte;
                stm_pkg::OFS_PERIOD_COMPARE:    period_value_reg <= wr_byte;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // external pin: two flops, then edge detection on the synced copy
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            pin_meta_reg <= 1'b0;
            pin_sync_reg <= 1'b0;
            pin_last_reg <= 1'b0;
        end else begin
            pin_meta_reg <= EXT_CLOCK_PIN_IN;
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    logic pin_rise;
    logic pin_fall;
    logic pin_edge;
    assign pin_rise = pin_sync_reg & ~pin_last_reg;
    assign pin_fall = ~pin_sync_reg & pin_last_reg;
    // falling-edge source picks the falling edge, everything else rising
    assign pin_edge = (clk_sel_reg == stm_pkg::CLK_PIN_FALL) ? pin_fall : pin_rise;

    // ----------------------------------------------------------------
    // counter clock tick
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            prescale_reg <= 8'h00;
        end else begin
            prescale_reg <= prescale_reg + 8'h01;
        end
    end

    logic tick;
    always_comb begin
        unique case (clk_sel_reg)
            stm_pkg::CLK_SYS_DIV4:  tick = (prescale_reg[1:0] == 2'h3);
            stm_pkg::CLK_SYS:       tick = 1'b1;
            stm_pkg::CLK_SYS_DIV16: tick = (prescale_reg[3:0] == 4'hF);
            stm_pkg::CLK_SYS_DIV64: tick = (prescale_reg[5:0] == 6'h3F);
            stm_pkg::CLK_PIN_RISE,
            stm_pkg::CLK_PIN_FALL:  tick = pin_edge;
            default:                tick = ({24'h0, prescale_reg} == 32'(TBC_DIV - 1));
        endcase
    end

    // ----------------------------------------------------------------
    // mode decode and comparators
    // ----------------------------------------------------------------
    logic        mode_cmp;
    logic        cmp_like;
    logic        mode_pwm_grp;
    logic        single_pulse;
    logic        on_rise;
    logic        run;
    logic        a_match;
    logic        p_match;
    logic        a_evt;
    logic        p_evt;
    logic        clear_cnt;
    logic [16:0] next_count;
    assign mode_cmp     = ctrl1_reg.mode == stm_pkg::STM_MODE_COMPARE;
    assign cmp_like     = mode_cmp | (ctrl1_reg.mode == stm_pkg::STM_MODE_TIMER);
    assign mode_pwm_grp = ctrl1_reg.mode == stm_pkg::STM_MODE_PWM;
    assign single_pulse = mode_pwm_grp
                          & (ctrl1_reg.output_function == stm_pkg::FUNC_TOGGLE_OR_PULSE);
    assign on_rise      = counter_on_reg & ~on_prev_reg;
    assign run          = counter_on_reg & ~counter_hold_reg & ~on_rise & tick;
    assign next_count   = {1'b0, count_reg} + 17'h00001;
    // match when the next count reaches the span; a zero span is overflow
    assign a_match      = next_count == word_span(compare_a_value_reg);
    assign p_match      = next_count == byte_span(period_value_reg);
    assign a_evt        = run & a_match;
    assign p_evt        = run & p_match & ~single_pulse;

    // clear source: clear select in compare modes, swap bit in pwm
    always_comb begin
        clear_cnt = 1'b0;
        if (cmp_like) begin
            clear_cnt = ctrl1_reg.clear_select ? a_evt : p_evt;
        end else if (mode_pwm_grp && !single_pulse) begin
            clear_cnt = ctrl1_reg.period_duty_swap ? a_evt : p_evt;
        end
    end

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            count_reg <= 16'h0000;
        end else if (on_rise) begin
            count_reg <= 16'h0000;
        end else if (clear_cnt) begin
            count_reg <= 16'h0000;
        end else if (run && !(single_pulse && a_match)) begin
            count_reg <= next_count[15:0];
        end
    end

    // ----------------------------------------------------------------
    // counter on bit: software, pin trigger, pulse end
    // ----------------------------------------------------------------
    logic ext_set;
    assign ext_set = single_pulse & pin_edge;

    // the pin trigger wins over both a software write and an a match
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            counter_on_reg <= 1'b0;
            on_prev_reg    <= 1'b0;
        end else begin
            on_prev_reg <= counter_on_reg;
            if (ext_set) begin
                counter_on_reg <= 1'b1;
            end else if (wr_now && AVS_ADDRESS_IN == stm_pkg::OFS_TIMER_CONTROL_ZERO) begin
                counter_on_reg <= wr_byte[stm_pkg::BIT_COUNTER_ON];
            end else if (single_pulse && a_evt) begin
                counter_on_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // match flags, write one to clear; a new match beats the clear
    // ----------------------------------------------------------------
    logic clr_status;
    logic set_a;
    logic set_p;
    assign clr_status = wr_now && AVS_ADDRESS_IN == stm_pkg::OFS_MATCH_STATUS;
    assign set_a      = a_evt & ~ctrl1_reg.mode[0] | a_evt & cmp_like;
    assign set_p      = p_evt & ~(cmp_like & ctrl1_reg.clear_select)
                        & (ctrl1_reg.mode != stm_pkg::STM_MODE_CAPTURE);

    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            match_a_flag_reg <= 1'b0;
            match_p_flag_reg <= 1'b0;
        end else begin
            match_a_flag_reg <= set_a
                | (match_a_flag_reg & ~(clr_status & wr_byte[stm_pkg::BIT_MATCH_A]));
            match_p_flag_reg <= set_p
                | (match_p_flag_reg & ~(clr_status & wr_byte[stm_pkg::BIT_MATCH_P]));
        end
    end

    // ----------------------------------------------------------------
    // compare mode output level
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            out_level_reg <= 1'b0;
        end else if (on_rise && mode_cmp) begin
            out_level_reg <= ctrl1_reg.output_control;
        end else if (a_evt && mode_cmp) begin
            unique case (ctrl1_reg.output_function)
                stm_pkg::FUNC_LOW_OR_ACTIVE:   out_level_reg <= 1'b0;
                stm_pkg::FUNC_HIGH_OR_PWM:     out_level_reg <= 1'b1;
                stm_pkg::FUNC_TOGGLE_OR_PULSE: out_level_reg <= ~out_level_reg;
                default:                       out_level_reg <= out_level_reg;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // pwm and pulse waveform; registered onto the pin
    // ----------------------------------------------------------------
    logic [16:0] duty_span;
    logic [16:0] period_span;
    logic        active;
    logic        pin_next;
    // swap picks which compare register sets the period
    assign period_span = ctrl1_reg.period_duty_swap
                         ? word_span(compare_a_value_reg) : byte_span(period_value_reg);
    assign duty_span   = ctrl1_reg.period_duty_swap
                         ? byte_span(period_value_reg) : {1'b0, compare_a_value_reg};

    // active level resolution; forced codes keep the counter running
    always_comb begin
        unique case (ctrl1_reg.output_function)
            stm_pkg::FUNC_NONE_OR_INACTIVE: active = 1'b0;
            stm_pkg::FUNC_LOW_OR_ACTIVE:    active = 1'b1;
            stm_pkg::FUNC_HIGH_OR_PWM:      active = ({1'b0, count_reg} < duty_span)
                                                     | (duty_span >= period_span);
            default:                        active = counter_on_reg;
        endcase
        pin_next = mode_pwm_grp ? (active ~^ ctrl1_reg.output_control) : out_level_reg;
    end

    // pin released in timer/counter and capture modes
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            pin_out_reg  <= 1'b0;
            pin_oe_n_reg <= 1'b1;
        end else begin
            pin_out_reg  <= pin_next ^ ctrl1_reg.output_invert;
            pin_oe_n_reg <= ~(mode_cmp | mode_pwm_grp);
        end
    end

    assign AVS_READDATA_OUT    = rdata_reg;
    assign AVS_WAITREQUEST_OUT = wait_reg;
    assign TIMER_OUT           = pin_out_reg;
    assign TIMER_OE_N_OUT      = pin_oe_n_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RESET_IN);

    AST_ON_RISE_ZERO: assert property (on_rise |=> count_reg == 16'h0000)
        else $error("counter not zeroed on counter on rise");
    AST_HOLD_FREEZE: assert property (counter_hold_reg && !on_rise |=> $stable(count_reg))
        else $error("counter moved while held");
    AST_INCREMENT: assert property (run && !clear_cnt && !a_match
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not step by one");
    AST_P_CLEAR: assert property (cmp_like && !ctrl1_reg.clear_select && p_evt
        |=> count_reg == 16'h0000 ##0 match_p_flag_reg)
        else $error("p match did not clear or flag");
    AST_NO_P_FLAG: assert property (cmp_like && ctrl1_reg.clear_select && !match_p_flag_reg
        |=> !match_p_flag_reg)
        else $error("p flag set with clear select high");
    AST_PIN_ONLY_A: assert property (mode_cmp && !a_evt && !on_rise
        |=> $stable(out_level_reg))
        else $error("compare output moved without a match");
    AST_SET_HIGH: assert property (mode_cmp && a_evt && !on_rise
        && ctrl1_reg.output_function == stm_pkg::FUNC_HIGH_OR_PWM |=> out_level_reg)
        else $error("output not driven high on a match");
    AST_INIT_LEVEL: assert property (mode_cmp && on_rise
        |=> out_level_reg == $past(ctrl1_reg.output_control))
        else $error("initial level not loaded");
    AST_TIMER_FREE: assert property (ctrl1_reg.mode == stm_pkg::STM_MODE_TIMER
        |=> TIMER_OE_N_OUT)
        else $error("pin driven in timer mode");
    AST_FULL_DUTY: assert property (mode_pwm_grp && duty_span >= period_span
        && ctrl1_reg.output_function == stm_pkg::FUNC_HIGH_OR_PWM
        |=> TIMER_OUT == $past(ctrl1_reg.output_control ^ ctrl1_reg.output_invert))
        else $error("pwm not held fully active");
    AST_PIN_TRIGGER: assert property (ext_set |=> counter_on_reg)
        else $error("pin edge did not set counter on");
    AST_PULSE_STOP: assert property (single_pulse && a_evt && !ext_set && !wr_now
        |=> !counter_on_reg ##1 $stable(count_reg))
        else $error("a match did not end the pulse");

    COV_PWM_WRAP: cover property (mode_pwm_grp && !single_pulse && clear_cnt);
    COV_PULSE: cover property (single_pulse && ext_set ##[1:300] (a_evt));
    COV_TOGGLE: cover property (mode_cmp && a_evt
        && ctrl1_reg.output_function == stm_pkg::FUNC_TOGGLE_OR_PULSE);
endmodule : stm_timer
`default_nettype wire

// ### rtl/stm_pkg.sv
/*
 * shared constants and types for the 16-bit standard timer: register word
 * offsets, bit positions, reset values, mode and output function codes.
 * assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
 */
package stm_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_TIMER_CONTROL_ZERO = 8'h00;
    localparam logic [7:0] OFS_TIMER_CONTROL_ONE  = 8'h04;
    localparam logic [7:0] OFS_COUNT_LOW          = 8'h08;
    localparam logic [7:0] OFS_COUNT_HIGH         = 8'h0C;
    localparam logic [7:0] OFS_COMPARE_A_LOW      = 8'h10;
    localparam logic [7:0] OFS_COMPARE_A_HIGH     = 8'h14;
    localparam logic [7:0] OFS_PERIOD_COMPARE     = 8'h18;
    localparam logic [7:0] OFS_MATCH_STATUS       = 8'h1C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int         BIT_COUNTER_HOLD = 7;
    localparam int         BIT_CLK_SEL_LSB  = 4;
    localparam int         BIT_COUNTER_ON   = 3;
    localparam int         BIT_MATCH_A      = 0;
    localparam int         BIT_MATCH_P      = 1;
    localparam logic [7:0] RST_BYTE         = 8'h00;

    // ----------------------------------------------------------------
    // counter clock sources
    // ----------------------------------------------------------------
    localparam logic [2:0] CLK_SYS_DIV4   = 3'h0;
    localparam logic [2:0] CLK_SYS        = 3'h1;
    localparam logic [2:0] CLK_SYS_DIV16  = 3'h2;
    localparam logic [2:0] CLK_SYS_DIV64  = 3'h3;
    localparam logic [2:0] CLK_PIN_RISE   = 3'h6;
    localparam logic [2:0] CLK_PIN_FALL   = 3'h7;

    // operating modes, two bits as in the control field
    typedef enum logic [1:0] {
        STM_MODE_COMPARE = 2'h0,
        STM_MODE_CAPTURE = 2'h1,
        STM_MODE_PWM     = 2'h2,
        STM_MODE_TIMER   = 2'h3
    } stm_mode_t;

    // output function codes
    localparam logic [1:0] FUNC_NONE_OR_INACTIVE = 2'h0;
    localparam logic [1:0] FUNC_LOW_OR_ACTIVE    = 2'h1;
    localparam logic [1:0] FUNC_HIGH_OR_PWM      = 2'h2;
    localparam logic [1:0] FUNC_TOGGLE_OR_PULSE  = 2'h3;

    // second control register, msb first as laid out in the byte
    typedef struct packed {
        stm_mode_t  mode;
        logic [1:0] output_function;
        logic       output_control;
        logic       output_invert;
        logic       period_duty_swap;
        logic       clear_select;
    } stm_ctrl1_t;
endpackage : stm_pkg

// ### bench/stm_pin_model.sv
/* far side: trigger source on the external clock pin, output pad.
   assumes a pull-down on the pad whenever the timer releases it. */
`timescale 1ns/1ps
`default_nettype none
module stm_pin_model (
    input  wire logic clk_in,
    input  wire logic fire_in,
    input  wire logic timer_in,
    input  wire logic timer_oe_n_in,
    output var  logic ext_pin_out,
    output var  logic pad_out
);
    // pulse of four cycles so both synchroniser stages see it
    initial ext_pin_out = 1'b0;
    always @(posedge clk_in) begin
        if (fire_in) begin
            ext_pin_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            ext_pin_out <= 1'b0;
        end
    end
    // released pad falls to the pull-down level
    assign pad_out = timer_oe_n_in ? 1'b0 : timer_in;
endmodule : stm_pin_model
`default_nettype wire

// ### bench/standard_timer_16bit_modes_bench.sv
/* register-level tests of the timer through avalon-mm.
   assumes the pin model above and one wait cycle or more per access. */
`timescale 1ns/1ps
`default_nettype none
module standard_timer_16bit_modes_bench;
    logic        clk, rst, rd, wr, fire, wreq, tout, oe_n, ext, pad;
    logic [7:0]  adr;
    logic [31:0] wd, rdata, q, q2;
    int          mismatches, checks_done;
    stm_timer #(.TBC_DIV(4)) i_dut (.CORE_CLK_IN(clk), .RESET_IN(rst),
        .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wd), .AVS_BYTEENABLE_IN(4'hF),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(wreq),
        .EXT_CLOCK_PIN_IN(ext), .TIMER_OUT(tout), .TIMER_OE_N_OUT(oe_n));
    stm_pin_model i_pin (.clk_in(clk), .fire_in(fire), .timer_in(tout),
        .timer_oe_n_in(oe_n), .ext_pin_out(ext), .pad_out(pad));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        // waitrequest and read data are taken at the same rising edge
        do begin
            @(posedge clk);
        end while (wreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic pin_at(input int c, input logic e);
        repeat (c) @(negedge clk);
        chk("pad", {31'h0, e}, {31'h0, pad});
        @(posedge clk);
    endtask : pin_at
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // watchdog: the tests need well under 2000 cycles
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end
    initial begin
        {rd, wr, fire, adr, wd, mismatches, checks_done} = '0;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(0, 8'h14, 8'h00); chk("cmp_a_hi", 32'h0, q);
        bus(0, 8'h18, 8'h00); chk("period", 32'h0, q);
        bus(0, 8'h20, 8'h00); chk("unmapped", 32'h0, q);
        $display("test reset done");
        bus(1, 8'h10, 8'h08);
        bus(1, 8'h14, 8'h01);
        bus(1, 8'h18, 8'h01);
        bus(1, 8'h04, 8'h21);
        bus(1, 8'h00, 8'h18);
        // a at 264 lies past p at 256, so a stray p flag would show
        repeat (300) @(posedge clk);
        bus(0, 8'h1C, 8'h00); chk("flags", 32'h1, q);
        pin_at(1, 1'b1);
        bus(1, 8'h00, 8'h10);
        bus(1, 8'h00, 8'h18);
        pin_at(3, 1'b0);
        bus(1, 8'h00, 8'h98);
        bus(0, 8'h08, 8'h00);
        q2 = q;
        bus(0, 8'h08, 8'h00); chk("held", q2, q);
        $display("test compare done");
        bus(1, 8'h00, 8'h10);
        bus(1, 8'h10, 8'h14);
        bus(1, 8'h14, 8'h00);
        bus(1, 8'h04, 8'hB8);
        bus(1, 8'h1C, 8'h03);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        pin_at(8, 1'b1);
        bus(0, 8'h00, 8'h00); chk("on", 32'h18, q);
        repeat (40) @(posedge clk);
        bus(0, 8'h00, 8'h00); chk("off", 32'h10, q);
        pin_at(1, 1'b0);
        $display("test pulse done");
        bus(1, 8'h18, 8'h01);
        bus(1, 8'h04, 8'hAA);
        bus(1, 8'h00, 8'h18);
        pin_at(40, 1'b1);
        bus(1, 8'h04, 8'h8A);
        pin_at(3, 1'b0);
        bus(0, 8'h08, 8'h00);
        q2 = q;
        bus(0, 8'h08, 8'h00);
        chk("pwm_run", (q2 + 32'h3) % 32'h14, q);
        $display("test pwm done");
        // timer mode with invert set: a driven pin would read high
        bus(1, 8'h04, 8'hC4);
        bus(1, 8'h1C, 8'h03);
        repeat (300) @(posedge clk);
        bus(0, 8'h1C, 8'h00);
        chk("tmr_flags", 32'h3, q);
        pin_at(1, 1'b0);
        chk("oe_n", 32'h1, {31'h0, oe_n});
        $display("test timer done");
        finish_test();
    end
endmodule : standard_timer_16bit_modes_bench
`default_nettype wire
